//--- hdl/lsio_pkg.sv
// Constants shared by the line-signal input/output supervision block.
`default_nettype none
package lsio_pkg;
  // ==========================================================================
  // Monitor command codes (write codes, RT given as its read code; read is the code with bit 0 set)
  localparam logic [7:0] LSIO_CMD_MODE  = 8'h4A;
  localparam logic [7:0] LSIO_CMD_IO    = 8'h52;
  localparam logic [7:0] LSIO_CMD_DIR   = 8'h54;
  localparam logic [7:0] LSIO_CMD_CFG2  = 8'h46;
  localparam logic [7:0] LSIO_CMD_DEB   = 8'hC8;
  localparam logic [7:0] LSIO_CMD_GKP   = 8'hE8;
  localparam logic [7:0] LSIO_CMD_RT    = 8'h4D;
  localparam logic [7:0] LSIO_CMD_MASK  = 8'h6C;
  localparam int         LSIO_RW_BIT    = 0;
  localparam int         LSIO_CLR_BIT   = 1;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] LSIO_MODE_RST  = 8'h0F;
  localparam logic [7:0] LSIO_DEB_RST   = 8'h20;
  localparam logic [7:0] LSIO_MASK_RST  = 8'hFF;
  localparam logic [3:0] LSIO_GKP_RST   = 4'h0;
  localparam logic [4:0] LSIO_DIR_RST   = 5'h00;
  localparam logic [1:0] LSIO_CFG2_RST  = 2'h2;
  // ==========================================================================
  // Field positions
  localparam int LSIO_OIS_BIT   = 5;
  localparam int LSIO_LPS_BIT   = 4;
  localparam int LSIO_MSE_BIT   = 7;
  localparam int LSIO_MSP_BIT   = 6;
  localparam int LSIO_HDT_LSB   = 2;
  localparam int LSIO_COE_BIT   = 0;
  localparam int LSIO_IDT_BIT   = 1;
  localparam int LSIO_CHP_BIT   = 0;
  localparam int LSIO_CFG2_LSB  = 6;
  // ==========================================================================
  // Link frame layout, 32 bits, most significant bit first
  localparam int LSIO_FRAME_BITS = 32;
  localparam int LSIO_FR_CHAN    = 30;
  localparam int LSIO_FR_MON     = 29;
  localparam int LSIO_FR_CI      = 28;
  localparam int LSIO_FR_CMD     = 20;
  localparam int LSIO_FR_DATA    = 12;
  localparam int LSIO_FR_CIDATA  = 5;
  localparam int LSIO_UP_RDATA   = 24;
  localparam int LSIO_UP_RVALID  = 23;
  localparam int LSIO_UP_CI      = 20;
  // ==========================================================================
  // Timing
  localparam int LSIO_MCLK_HZ     = 40_000_000;
  localparam int LSIO_MS_PER_S    = 1000;
  localparam int LSIO_CYC_PER_MS  = LSIO_MCLK_HZ / LSIO_MS_PER_S;
  localparam int LSIO_CHOP_LO_HZ  = 256_000;
  localparam int LSIO_CHOP_HI_HZ  = 292_570;
  localparam logic [7:0] LSIO_CHOP_LO_HALF = 8'(LSIO_MCLK_HZ / (2 * LSIO_CHOP_LO_HZ));
  localparam logic [7:0] LSIO_CHOP_HI_HALF = 8'(LSIO_MCLK_HZ / (2 * LSIO_CHOP_HI_HZ));
endpackage
`default_nettype wire

//--- hdl/lsio_debounce.sv
// Millisecond debouncer for one synchronised input.
`timescale 1ns/1ps
`default_nettype none
module lsio_debounce
  import lsio_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       sample_in,
  input  wire logic       sample_en,
  input  wire logic       ms_tick,
  input  wire logic [3:0] limit_ms,
  output logic            stable_out
);
  logic [3:0] cnt_reg;
  logic       stable_reg;

  // ==========================================================================
  // The output follows only after the input has held for the set time.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg    <= 4'h0;
      stable_reg <= 1'b0;
    end else if (sample_in == stable_reg) begin
      cnt_reg <= 4'h0;
    end else if (sample_en) begin
      if (cnt_reg >= limit_ms) begin
        stable_reg <= sample_in;
        cnt_reg    <= 4'h0;
      end else if (ms_tick) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  assign stable_out = stable_reg;
endmodule
`default_nettype wire

//--- hdl/lsio_gci_link.sv
// Serial link framer: samples the link clock, shifts frames in and out.
`timescale 1ns/1ps
`default_nettype none
module lsio_gci_link
  import lsio_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        dclk_pin,
  input  wire logic        fsc_pin,
  input  wire logic        dd_pin,
  input  wire logic [31:0] up_word,
  output logic             rx_valid,
  output logic [31:0]      rx_word,
  output logic             du_out,
  output logic             du_oe
);
  logic [2:0]  s1_reg;
  logic [2:0]  s2_reg;
  logic        dclk_prev_reg;
  logic        active_reg;
  logic [5:0]  bit_reg;
  logic [31:0] rx_sh_reg;
  logic [31:0] tx_sh_reg;
  logic        rx_valid_reg;
  logic [31:0] rx_word_reg;
  logic        du_oe_reg;
  logic        rise;
  logic        fall;

  // ==========================================================================
  // Two-stage synchronisers for the link pins.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_reg        <= 3'h5;
      s2_reg        <= 3'h5;
      dclk_prev_reg <= 1'b1;
    end else begin
      s1_reg        <= {dclk_pin, fsc_pin, dd_pin};
      s2_reg        <= s1_reg;
      dclk_prev_reg <= s2_reg[2];
    end
  end

  assign rise = s2_reg[2] & ~dclk_prev_reg;
  assign fall = ~s2_reg[2] & dclk_prev_reg;

  // ==========================================================================
  // Receive on rising link clock, frame starts where frame sync is high.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_reg   <= 1'b0;
      bit_reg      <= 6'h0;
      rx_sh_reg    <= 32'h0;
      rx_valid_reg <= 1'b0;
      rx_word_reg  <= 32'h0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (rise) begin
        if (s2_reg[1]) begin
          active_reg <= 1'b1;
          bit_reg    <= 6'h1;
          rx_sh_reg  <= {31'h0, s2_reg[0]};
        end else if (active_reg) begin
          rx_sh_reg <= {rx_sh_reg[30:0], s2_reg[0]};
          if (bit_reg == 6'(LSIO_FRAME_BITS - 1)) begin
            active_reg   <= 1'b0;
            rx_valid_reg <= 1'b1;
            rx_word_reg  <= {rx_sh_reg[30:0], s2_reg[0]};
          end
          bit_reg <= bit_reg + 6'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Transmit on falling link clock; open drain, driven only for a zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_sh_reg <= 32'hFFFFFFFF;
      du_oe_reg <= 1'b0;
    end else if (rise && s2_reg[1]) begin
      tx_sh_reg <= up_word;
    end else if (fall) begin
      du_oe_reg <= active_reg & ~tx_sh_reg[31];
      tx_sh_reg <= {tx_sh_reg[30:0], 1'b1};
    end
  end

  assign rx_valid = rx_valid_reg;
  assign rx_word  = rx_word_reg;
  assign du_out   = 1'b0;
  assign du_oe    = du_oe_reg;
endmodule
`default_nettype wire

//--- hdl/lsio_top.sv
// Line-signal input/output and supervision block for a four-channel codec.
// ============================================================================
`timescale 1ns/1ps
`default_nettype none
module lsio_top
  import lsio_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = LSIO_CYC_PER_MS
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       dclk_pin,
  input  wire logic       fsc_pin,
  input  wire logic       dd_pin,
  output logic            du_out,
  output logic            du_oe,
  input  wire logic [3:0] detect_pin_one_in,
  output logic      [3:0] detect_pin_one_out,
  output logic      [3:0] detect_pin_one_oe,
  input  wire logic [3:0] detect_pin_two_in,
  output logic      [3:0] detect_pin_two_out,
  output logic      [3:0] detect_pin_two_oe,
  input  wire logic [3:0] line_pin_three_in,
  output logic      [3:0] line_pin_three_out,
  output logic      [3:0] line_pin_three_oe,
  input  wire logic [3:0] line_pin_four_in,
  output logic      [3:0] line_pin_four_out,
  output logic      [3:0] line_pin_four_oe,
  input  wire logic [3:0] line_pin_five_in,
  output logic      [3:0] line_pin_five_out,
  output logic      [3:0] line_pin_five_oe,
  output logic      [3:0] line_pin_six,
  output logic      [3:0] line_pin_seven,
  input  wire logic [3:0] channel_active,
  output logic      [3:0] voice_output_hiz,
  output logic            mux_strobe,
  output logic            chopper_clk,
  output logic            irq_n_out,
  output logic            irq_n_oe
);
  // ==========================================================================
  // Declarations
  logic [7:0]  mode_reg, deb_reg, mask_reg, rt_prev_reg, chop_cnt_reg, rdata_reg;
  logic [7:0]  rt, cmd, wdata;
  logic [1:0]  cfg2_reg, up_chan_reg, chan;
  logic [4:0]  dir_reg [4];
  logic [6:0]  outlat_reg [4];
  logic [19:0] pin_s1_reg, pin_s2_reg;
  logic [15:0] ms_cnt_reg;
  logic [3:0]  gkp_reg, gkp_cnt_reg, ssb_reg, vhiz_reg;
  logic [3:0]  d1_s, d2_s, p3_s, p4_s, p5_s, dfb, muxed_hook_bit;
  logic        ms_tick_reg, phase_reg, mux_strobe_reg, pend_reg, irq_out_reg, irq_oe_reg;
  logic        chop_reg, rvalid_reg, rx_valid, mon_ok, rt_clear, mse, rt_event, gkp_sample;
  logic [31:0] rx_word, up_word;
  logic [2:0]  ci_up;

  function automatic logic cmd_is(input logic [7:0] c, input logic [7:0] base);
    cmd_is = (c[7:1] == base[7:1]);
  endfunction

  assign mse    = deb_reg[LSIO_MSE_BIT];
  assign chan   = rx_word[LSIO_FR_CHAN +: 2];
  assign cmd    = rx_word[LSIO_FR_CMD +: 8];
  assign wdata  = rx_word[LSIO_FR_DATA +: 8];
  assign mon_ok = rx_valid & rx_word[LSIO_FR_MON];
  assign rt_clear = mon_ok && (cmd[7:2] == LSIO_CMD_RT[7:2]) && cmd[LSIO_RW_BIT]
                    && cmd[LSIO_CLR_BIT];

  // ==========================================================================
  // Link framer
  lsio_gci_link u_link (
    .mclk     (mclk),
    .rst      (rst),
    .dclk_pin (dclk_pin),
    .fsc_pin  (fsc_pin),
    .dd_pin   (dd_pin),
    .up_word  (up_word),
    .rx_valid (rx_valid),
    .rx_word  (rx_word),
    .du_out   (du_out),
    .du_oe    (du_oe)
  );

  // ==========================================================================
  // Line pin synchronisers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 20'h0;
      pin_s2_reg <= 20'h0;
    end else begin
      pin_s1_reg <= {line_pin_five_in, line_pin_four_in, line_pin_three_in,
                     detect_pin_two_in, detect_pin_one_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign d1_s = pin_s2_reg[3:0];
  assign d2_s = pin_s2_reg[7:4];
  assign p3_s = pin_s2_reg[11:8];
  assign p4_s = pin_s2_reg[15:12];
  assign p5_s = pin_s2_reg[19:16];

  // ==========================================================================
  // Millisecond tick and multiplex strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ms_cnt_reg  <= 16'h0;
      ms_tick_reg <= 1'b0;
    end else begin
      ms_tick_reg <= (ms_cnt_reg == 16'(CYC_PER_MS - 1));
      if (ms_cnt_reg == 16'(CYC_PER_MS - 1)) begin
        ms_cnt_reg <= 16'h0;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 16'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg      <= 1'b0;
      mux_strobe_reg <= 1'b0;
    end else begin
      if (!mse) begin
        phase_reg <= 1'b0;
      end else if (ms_tick_reg) begin
        phase_reg <= ~phase_reg;
      end
      mux_strobe_reg <= phase_reg ^ deb_reg[LSIO_MSP_BIT];
    end
  end

  // ==========================================================================
  // Per-channel debouncing and real-time byte
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chan
      lsio_debounce u_first (
        .mclk       (mclk),
        .rst        (rst),
        .sample_in  (d1_s[c]),
        .sample_en  (~mse | ~phase_reg),
        .ms_tick    (ms_tick_reg),
        .limit_ms   (deb_reg[LSIO_HDT_LSB +: 4]),
        .stable_out (dfb[c])
      );
      lsio_debounce u_hook (
        .mclk       (mclk),
        .rst        (rst),
        .sample_in  (d1_s[c]),
        .sample_en  (mse & phase_reg),
        .ms_tick    (ms_tick_reg),
        .limit_ms   (deb_reg[LSIO_HDT_LSB +: 4]),
        .stable_out (muxed_hook_bit[c])
      );
      assign rt[2*c]     = dfb[c];
      assign rt[2*c + 1] = ssb_reg[c];
    end
  endgenerate

  // ==========================================================================
  // Ground-key sampling of the second signal bit
  assign gkp_sample = (gkp_reg == 4'h0) || (ms_tick_reg && (gkp_cnt_reg >= gkp_reg - 4'h1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gkp_cnt_reg <= 4'h0;
      ssb_reg     <= 4'h0;
    end else begin
      if (gkp_sample) begin
        gkp_cnt_reg <= 4'h0;
        ssb_reg     <= mse ? muxed_hook_bit : d2_s;
      end else if (ms_tick_reg) begin
        gkp_cnt_reg <= gkp_cnt_reg + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Interrupt pending and output drive
  assign rt_event = |((rt ^ rt_prev_reg) & ~mask_reg);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rt_prev_reg <= 8'h0;
      pend_reg    <= 1'b0;
      irq_out_reg <= 1'b1;
      irq_oe_reg  <= 1'b1;
    end else begin
      rt_prev_reg <= rt;
      if (rt_event) begin
        pend_reg <= 1'b1;
      end else if (rt_clear) begin
        pend_reg <= 1'b0;
      end
      irq_out_reg <= cfg2_reg[LSIO_IDT_BIT] ? 1'b0 : ~pend_reg;
      irq_oe_reg  <= cfg2_reg[LSIO_IDT_BIT] ? pend_reg : 1'b1;
    end
  end

  // ==========================================================================
  // Chopper clock and voice output idle mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chop_cnt_reg <= 8'h0;
      chop_reg     <= 1'b0;
      vhiz_reg     <= 4'h0;
    end else begin
      vhiz_reg <= {4{mode_reg[LSIO_OIS_BIT]}} & ~channel_active;
      if (!deb_reg[LSIO_COE_BIT]) begin
        chop_cnt_reg <= 8'h0;
        chop_reg     <= 1'b0;
      end else if (chop_cnt_reg == (cfg2_reg[LSIO_CHP_BIT] ? LSIO_CHOP_HI_HALF
                                                           : LSIO_CHOP_LO_HALF) - 8'h1) begin
        chop_cnt_reg <= 8'h0;
        chop_reg     <= ~chop_reg;
      end else begin
        chop_cnt_reg <= chop_cnt_reg + 8'h1;
      end
    end
  end

  // ==========================================================================
  // Monitor command writes, C/I pin control, read answers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg  <= LSIO_MODE_RST;
      cfg2_reg  <= LSIO_CFG2_RST;
      deb_reg   <= LSIO_DEB_RST;
      gkp_reg   <= LSIO_GKP_RST;
      mask_reg  <= LSIO_MASK_RST;
      for (int i = 0; i < 4; i++) begin
        dir_reg[i]    <= LSIO_DIR_RST;
        outlat_reg[i] <= 7'h0;
      end
    end else if (rx_valid) begin
      if (mon_ok && !cmd[LSIO_RW_BIT]) begin
        if (cmd_is(cmd, LSIO_CMD_MODE)) mode_reg <= wdata;
        if (cmd_is(cmd, LSIO_CMD_CFG2)) cfg2_reg <= wdata[LSIO_CFG2_LSB +: 2];
        if (cmd_is(cmd, LSIO_CMD_DEB)) deb_reg <= wdata;
        if (cmd_is(cmd, LSIO_CMD_GKP)) gkp_reg <= wdata[3:0];
        if (cmd_is(cmd, LSIO_CMD_MASK)) mask_reg <= wdata;
        if (cmd_is(cmd, LSIO_CMD_DIR)) dir_reg[chan] <= wdata[4:0];
        if (cmd == LSIO_CMD_IO) outlat_reg[chan] <= {wdata[7:6], wdata[4:0]};
      end
      if (rx_word[LSIO_FR_CI]) begin
        outlat_reg[chan] <= rx_word[LSIO_FR_CIDATA +: 7];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg   <= 8'h0;
      rvalid_reg  <= 1'b0;
      up_chan_reg <= 2'h0;
    end else if (rx_valid) begin
      up_chan_reg <= chan;
      rvalid_reg  <= mon_ok & cmd[LSIO_RW_BIT];
      rdata_reg   <= 8'h0;
      if (mon_ok && cmd[LSIO_RW_BIT]) begin
        if (cmd_is(cmd, LSIO_CMD_MODE)) rdata_reg <= mode_reg;
        if (cmd_is(cmd, LSIO_CMD_CFG2)) rdata_reg <= {cfg2_reg, 6'h0};
        if (cmd_is(cmd, LSIO_CMD_DEB)) rdata_reg <= deb_reg;
        if (cmd_is(cmd, LSIO_CMD_GKP)) rdata_reg <= {4'h0, gkp_reg};
        if (cmd_is(cmd, LSIO_CMD_MASK)) rdata_reg <= mask_reg;
        if (cmd_is(cmd, LSIO_CMD_DIR)) rdata_reg <= {3'h0, dir_reg[chan]};
        if (cmd[7:2] == LSIO_CMD_RT[7:2]) rdata_reg <= rt;
        if (cmd_is(cmd, LSIO_CMD_IO)) begin
          rdata_reg <= {outlat_reg[chan][6:5], muxed_hook_bit[chan] & mse, p5_s[chan],
                        p4_s[chan], p3_s[chan], d2_s[chan], d1_s[chan]};
        end
      end
    end
  end

  // Upstream C/I carries only pins that are inputs.
  assign ci_up = {dfb[up_chan_reg] & ~dir_reg[up_chan_reg][0],
                  ssb_reg[up_chan_reg] & ~dir_reg[up_chan_reg][1],
                  p3_s[up_chan_reg] & ~dir_reg[up_chan_reg][2]};
  assign up_word = {rdata_reg, rvalid_reg, ci_up, 20'hFFFFF};

  // ==========================================================================
  // Output ports
  generate
    for (c = 0; c < 4; c++) begin : g_pins
      assign detect_pin_one_out[c] = outlat_reg[c][0];
      assign detect_pin_two_out[c] = outlat_reg[c][1];
      assign line_pin_three_out[c] = outlat_reg[c][2];
      assign line_pin_four_out[c]  = outlat_reg[c][3];
      assign line_pin_five_out[c]  = outlat_reg[c][4];
      assign line_pin_six[c]       = outlat_reg[c][5];
      assign line_pin_seven[c]     = outlat_reg[c][6];
      assign detect_pin_one_oe[c]  = dir_reg[c][0];
      assign detect_pin_two_oe[c]  = dir_reg[c][1];
      assign line_pin_three_oe[c]  = dir_reg[c][2];
      assign line_pin_four_oe[c]   = dir_reg[c][3];
      assign line_pin_five_oe[c]   = dir_reg[c][4];
    end
  endgenerate

  assign voice_output_hiz = vhiz_reg;
  assign mux_strobe       = mux_strobe_reg;
  assign chopper_clk      = chop_reg;
  assign irq_n_out        = irq_out_reg;
  assign irq_n_oe         = irq_oe_reg;
endmodule
`default_nettype wire

//--- sim/lsio_top_chk.sv
// Assertion checker for the line-signal supervision block.
`timescale 1ns/1ps
`default_nettype none
module lsio_top_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       dclk_pin,
  input wire logic       du_out,
  input wire logic       du_oe,
  input wire logic [3:0] channel_active,
  input wire logic [3:0] voice_output_hiz,
  input wire logic       mux_strobe,
  input wire logic       chopper_clk,
  input wire logic       irq_n_out,
  input wire logic       irq_n_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Hold sequences and properties.
  sequence chop_hi_s; chopper_clk [*8]; endsequence
  sequence chop_lo_s; !chopper_clk [*8]; endsequence
  sequence irq_held_s; irq_n_oe [*8]; endsequence
  sequence link_idle_s; dclk_pin [*8]; endsequence
  irq_kind_a: assert property (!(irq_n_out && !irq_n_oe))
    else $error("Interrupt pin released while driven high");
  du_low_a: assert property (du_out == 1'b0) else $error("Upstream data driven high");
  du_idle_a: assert property (link_idle_s |-> $stable(du_oe))
    else $error("Upstream line moved while link idle");
  chop_hold_a: assert property ($rose(chopper_clk) |=> chop_hi_s)
    else $error("Chopper high phase too short");
  chop_low_a: assert property ($fell(chopper_clk) |=> chop_lo_s)
    else $error("Chopper low phase too short");
  strobe_hold_a: assert property ($changed(mux_strobe) |=> $stable(mux_strobe) [*8])
    else $error("Strobe toggled too fast");
  hiz_active_a: assert property ((voice_output_hiz & channel_active & $past(channel_active)) == 4'h0)
    else $error("Active channel voice output floated");
  irq_hold_a: assert property ($rose(irq_n_oe) && !irq_n_out |=> irq_held_s)
    else $error("Interrupt dropped without clearing read");
endmodule
`default_nettype wire

//--- sim/lsio_gci_model.sv
// Behavioural upstream controller that drives the serial link.
`timescale 1ns/1ps
`default_nettype none
module lsio_gci_model (
  output logic      dclk_pin,
  output logic      fsc_pin,
  output logic      dd_pin,
  input  wire logic du_oe
);
  initial begin
    dclk_pin = 1'b1;
    fsc_pin  = 1'b0;
    dd_pin   = 1'b1;
  end
  // ==========================================================================
  // One frame; the link clock stands high between frames, data idles pulled up.
  task automatic xfer(input logic [31:0] down, output logic [31:0] up);
    for (int i = 32; i >= 0; i--) begin
      dclk_pin <= 1'b0;
      fsc_pin  <= (i == 32);
      dd_pin   <= (i > 0) ? down[i-1] : 1'b1;
      #100;
      if (i < 32) up[i] = ~du_oe;
      dclk_pin <= 1'b1;
      #100;
    end
  endtask
endmodule
`default_nettype wire

//--- sim/lsio_top_tb.sv
// Self-checking bench for the line-signal supervision block.
`timescale 1ns/1ps
`default_nettype none
module lsio_top_tb;
  logic        mclk, rst, dclk_pin, fsc_pin, dd_pin, du_out, du_oe;
  logic        mux_strobe, chopper_clk, irq_n_out, irq_n_oe;
  logic [3:0]  detect_pin_one_in, detect_pin_one_out, detect_pin_one_oe, d1_drv;
  logic [3:0]  detect_pin_two_in, detect_pin_two_out, detect_pin_two_oe, d2_drv;
  logic [3:0]  line_pin_three_in, line_pin_three_out, line_pin_three_oe, p3_drv;
  logic [3:0]  line_pin_four_in, line_pin_four_out, line_pin_four_oe, p4_drv;
  logic [3:0]  line_pin_five_in, line_pin_five_out, line_pin_five_oe, p5_drv;
  logic [3:0]  line_pin_six, line_pin_seven, channel_active, voice_output_hiz;
  logic [31:0] up;
  logic [15:0] n_ch, n_st;
  int          err_total, comparisons;
  // ==========================================================================
  // Wire levels of the two-way line pins.
  assign detect_pin_one_in = detect_pin_one_oe & detect_pin_one_out | ~detect_pin_one_oe & d1_drv;
  assign detect_pin_two_in = detect_pin_two_oe & detect_pin_two_out | ~detect_pin_two_oe & d2_drv;
  assign line_pin_three_in = line_pin_three_oe & line_pin_three_out | ~line_pin_three_oe & p3_drv;
  assign line_pin_four_in  = line_pin_four_oe & line_pin_four_out | ~line_pin_four_oe & p4_drv;
  assign line_pin_five_in  = line_pin_five_oe & line_pin_five_out | ~line_pin_five_oe & p5_drv;
  lsio_top #(.CYC_PER_MS(40)) dut (
    .mclk, .rst, .dclk_pin, .fsc_pin, .dd_pin, .du_out, .du_oe,
    .detect_pin_one_in, .detect_pin_one_out, .detect_pin_one_oe,
    .detect_pin_two_in, .detect_pin_two_out, .detect_pin_two_oe,
    .line_pin_three_in, .line_pin_three_out, .line_pin_three_oe,
    .line_pin_four_in, .line_pin_four_out, .line_pin_four_oe,
    .line_pin_five_in, .line_pin_five_out, .line_pin_five_oe,
    .line_pin_six, .line_pin_seven, .channel_active, .voice_output_hiz,
    .mux_strobe, .chopper_clk, .irq_n_out, .irq_n_oe);
  lsio_gci_model gci (.dclk_pin, .fsc_pin, .dd_pin, .du_oe);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] data, input logic civ,
                       input logic [6:0] ci);
    gci.xfer({2'b00, cmd != 8'h00, civ, cmd, data, ci, 5'h00}, up);
    repeat (8) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input logic [7:0] msk);
    frame(cmd, 8'h00, 1'b0, 7'h00);
    frame(8'h00, 8'h00, 1'b0, 7'h00);
    check({up[23], up[31:24] & msk}, {1'b1, exp});
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    channel_active = 4'h0;
    {d1_drv, d2_drv, p3_drv, p4_drv, p5_drv} = '0;
    err_total = 0;
    comparisons = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check(detect_pin_one_oe | line_pin_five_oe, 4'h0);
    check(voice_output_hiz, 4'h0);
    rd(8'h4B, 8'h0F, 8'hFF);
    rd(8'hC9, 8'h20, 8'hFD);
    rd(8'h6D, 8'hFF, 8'hFF);
    frame(8'h4A, 8'h30, 1'b0, 7'h00);
    rd(8'h4B, 8'h30, 8'h30);
    channel_active <= 4'h1;
    repeat (3) @(posedge mclk);
    check(voice_output_hiz, 4'hE);
    frame(8'hC8, 8'h00, 1'b0, 7'h00);
    frame(8'hE8, 8'h03, 1'b0, 7'h00);
    rd(8'hE9, 8'h03, 8'h0F);
    frame(8'h6C, 8'hFE, 1'b0, 7'h00);
    d1_drv <= 4'h1;
    repeat (20) @(posedge mclk);
    check({irq_n_oe, irq_n_out}, 2'b10);
    rd(8'h4D, 8'h01, 8'hFF);
    check(up[22:20], 3'b100);
    check(irq_n_oe, 1'b1);
    rd(8'h4F, 8'h01, 8'hFF);
    check(irq_n_oe, 1'b0);
    d2_drv <= 4'h2;
    p4_drv <= 4'h1;
    repeat (200) @(posedge mclk);
    check(irq_n_oe, 1'b0);
    rd(8'h4D, 8'h09, 8'hFF);
    frame(8'h46, 8'h00, 1'b0, 7'h00);
    check({irq_n_oe, irq_n_out}, 2'b11);
    rd(8'h53, 8'h09, 8'hDF);
    frame(8'h54, 8'h1F, 1'b0, 7'h00);
    check(detect_pin_one_oe, 4'h1);
    frame(8'h52, 8'hFF, 1'b0, 7'h00);
    check({line_pin_seven[0], line_pin_six[0], line_pin_five_out[0], line_pin_four_out[0],
           line_pin_three_out[0], detect_pin_two_out[0], detect_pin_one_out[0]}, 7'h7F);
    frame(8'h00, 8'h00, 1'b1, 7'h55);
    check({line_pin_seven[0], line_pin_six[0], line_pin_five_out[0], line_pin_four_out[0],
           line_pin_three_out[0], detect_pin_two_out[0], detect_pin_one_out[0]}, 7'h55);
    rd(8'h53, 8'h95, 8'hDF);
    check(up[22:20], 3'b000);
    check(chopper_clk, 1'b0);
    frame(8'hC8, 8'h81, 1'b0, 7'h00);
    n_ch = 16'h0000;
    n_st = 16'h0000;
    repeat (3120) begin
      @(negedge mclk);
      n_ch = n_ch + 16'(chopper_clk);
      n_st = n_st + 16'(mux_strobe);
    end
    check(n_ch, 16'h0618);
    check(n_st, 16'h0618);
    rd(8'h53, 8'hB5, 8'hFF);
    tally_and_finish();
  end
endmodule
bind lsio_top lsio_top_chk chk (.mclk, .rst, .dclk_pin, .du_out, .du_oe, .channel_active,
  .voice_output_hiz, .mux_strobe, .chopper_clk, .irq_n_out, .irq_n_oe);
`default_nettype wire
